// ==== hdl/jtag_tap_controller.sv ====
// Test-access-port controller with instruction and data shift registers.
// Assumes the test clock is a slow pin sampled by ref_clk, at most half its rate.
`timescale 1ns/1ps

// How it works
// - Mode select is sampled at each test-clock rise to pick the next state.
// - Serial data in shifts into the selected register on test-clock rise.
// - Serial data out changes only on the test-clock fall.
// - A sixteen-state machine drives capture and shift of all registers, and update of the instruction and debug control registers.
// - One operation loads and unloads exactly one register.
// - The shifted register depends on controller state and current instruction.
// - Separate shift paths exist for the instruction and data registers.
// - The instruction register is four bits, serially loaded and unloaded.
// - Data registers capture stimuli serially and shift results out serially.
// - Upper four instruction bits are ours, lower three belong to the chained one.
// - Codes: external test 1111_000, sample 1111_010, identity 1111_011, 1111_001 reserved.
// - Codes: high impedance 1111_101, clamp 1111_110, bypass 1111_111.
// - Eight private debug codes end in 100 with the listed upper nibbles.
// - Test clock is asynchronous; both of its edges are synchronised and used.
// - An output enable marks when serial data out is valid.
// - A flag is raised while the external test instruction is current.
// - Three flags mirror the capture, shift and update data states.
// - An output mirrors the program bit of the debug control register.
// - The output enable drops whenever nothing is being shifted.
// - Update data copies the register to parallel outputs on the fall.
module jtag_tap_controller
  import jtag_tap_pkg::*;
#(
  parameter logic [31:0] IDCODE_VALUE = IDCODE_DEFAULT
) (
  // Core clock and reset.
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // Test port pins.
  input  wire logic                    test_clock_in,
  input  wire logic                    test_mode_select_in,
  input  wire logic                    test_data_in,
  input  wire logic                    test_reset_n_in,
  input  wire logic                    chain_scan_in,
  // Current contents of the chained three-bit instruction register.
  input  wire logic [LOW_IR_WIDTH-1:0] chained_ir_low_in,
  // Serial output and its enable.
  output logic                         test_data_out,
  output logic                         test_data_out_enable,
  // Status outputs.
  output logic                         external_test_selected,
  output logic                         capture_data_state,
  output logic                         shift_data_state,
  output logic                         update_data_state,
  output logic                         debug_program_bit_out
);

  // Standard transition diagram of the controller.
  function automatic tap_state_e tap_next(input tap_state_e cur, input logic tms);
    tap_state_e nxt;
    nxt = TEST_LOGIC_RESET;
    case (cur)
      TEST_LOGIC_RESET: nxt = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE:    nxt = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
      SELECT_DR_SCAN:   nxt = tms ? SELECT_IR_SCAN : CAPTURE_DR;
      CAPTURE_DR:       nxt = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:         nxt = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:         nxt = tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:         nxt = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:         nxt = tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:        nxt = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
      SELECT_IR_SCAN:   nxt = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR:       nxt = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:         nxt = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:         nxt = tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:         nxt = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:         nxt = tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:        nxt = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
      default:          nxt = TEST_LOGIC_RESET;
    endcase
    return nxt;
  endfunction

  // True for one of the eight private debug codes.
  function automatic logic is_private(input logic [INSTR_WIDTH-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (code == {PRIVATE_NIBBLES[4*i +: 4], PRIVATE_LOW}) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Maps the combined seven-bit instruction to a data register.
  function automatic dr_select_e decode(input logic [INSTR_WIDTH-1:0] code);
    dr_select_e sel;
    sel = SEL_BYPASS;
    case (code)
      INSTR_EXTEST:     sel = SEL_BOUNDARY;
      INSTR_SAMPLE:     sel = SEL_BOUNDARY;
      INSTR_IDCODE:     sel = SEL_IDCODE;
      INSTR_DEBUG_CTRL: sel = SEL_DEBUG_CTRL;
      INSTR_HIGHZ:      sel = SEL_BYPASS;
      INSTR_CLAMP:      sel = SEL_BYPASS;
      INSTR_BYPASS:     sel = SEL_BYPASS;
      INSTR_RESERVED:   sel = SEL_BYPASS;
      default:          sel = SEL_BYPASS;
    endcase
    return sel;
  endfunction

  logic [SYNC_WIDTH-1:0]   sync_meta;
  logic [SYNC_WIDTH-1:0]   sync_q;
  logic                    tck_prev;
  logic                    tck_rise;
  logic                    tck_fall;
  logic                    tms_s;
  logic                    tdi_s;
  logic                    trst_n_s;
  logic                    chain_s;
  logic [LOW_IR_WIDTH-1:0] low_ir_s;

  tap_state_e              state;
  tap_state_e              next_state;

  logic [IR_WIDTH-1:0]     ir_shift;
  logic [IR_WIDTH-1:0]     ir_current;
  logic [INSTR_WIDTH-1:0]  instr;
  dr_select_e              dr_sel;
  logic                    private_code;

  logic                    bypass_reg;
  logic [IDCODE_WIDTH-1:0] idcode_shift;
  logic [DEBUG_CTRL_W-1:0] debug_shift;
  logic [DEBUG_CTRL_W-1:0] test_debug_control_reg;
  logic                    boundary_bit;
  logic                    next_tdo;

  // Two flip-flops stand between every pin and the logic that reads it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_meta <= SYNC_RESET;
      sync_q    <= SYNC_RESET;
    end else begin
      sync_meta <= {test_clock_in, test_mode_select_in, test_data_in, test_reset_n_in,
                    chain_scan_in, chained_ir_low_in};
      sync_q    <= sync_meta;
    end
  end

  // Both test-clock edges are found here; the reset value is the idle pin level,
  // so leaving reset does not fake an edge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tck_prev <= SYNC_RESET[SYNC_TCK];
    end else begin
      tck_prev <= sync_q[SYNC_TCK];
    end
  end

  assign tck_rise = sync_q[SYNC_TCK] & ~tck_prev;
  assign tck_fall = ~sync_q[SYNC_TCK] & tck_prev;
  assign tms_s    = sync_q[SYNC_TMS];
  assign tdi_s    = sync_q[SYNC_TDI];
  assign trst_n_s = sync_q[SYNC_TRST_N];
  assign chain_s  = sync_q[SYNC_CHAIN];
  assign low_ir_s = sync_q[LOW_IR_WIDTH-1:0];

  // The upper nibble is ours, the low bits come from the chained register.
  assign instr        = {ir_current, low_ir_s};
  assign dr_sel       = decode(instr);
  assign private_code = is_private(instr);

  assign next_state = tap_next(state, tms_s);

  // Controller state moves on each test-clock rise; test reset wins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= TEST_LOGIC_RESET;
    end else if (!trst_n_s) begin
      state <= TEST_LOGIC_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // Indicators are registered from the next state so they change with the state.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      capture_data_state <= 1'b0;
      shift_data_state   <= 1'b0;
      update_data_state  <= 1'b0;
    end else if (!trst_n_s) begin
      capture_data_state <= 1'b0;
      shift_data_state   <= 1'b0;
      update_data_state  <= 1'b0;
    end else if (tck_rise) begin
      capture_data_state <= (next_state == CAPTURE_DR);
      shift_data_state   <= (next_state == SHIFT_DR);
      update_data_state  <= (next_state == UPDATE_DR);
    end
  end

  // Instruction shift path: capture, then one bit per test-clock rise.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_shift <= IR_RESET;
    end else if (!trst_n_s || state == TEST_LOGIC_RESET) begin
      ir_shift <= IR_RESET;
    end else if (tck_rise && state == CAPTURE_IR) begin
      ir_shift <= IR_CAPTURE;
    end else if (tck_rise && state == SHIFT_IR) begin
      ir_shift <= {tdi_s, ir_shift[IR_WIDTH-1:1]};
    end
  end

  // The current instruction changes only on the fall in update-IR.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_current <= IR_RESET;
    end else if (!trst_n_s || state == TEST_LOGIC_RESET) begin
      ir_current <= IR_RESET;
    end else if (tck_fall && state == UPDATE_IR) begin
      ir_current <= ir_shift;
    end
  end

  // Data shift paths; only the register that the instruction selects moves.
  // Bypass stage: captures zero, then passes one bit per shift.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && dr_sel == SEL_BYPASS) begin
      if (state == CAPTURE_DR) begin
        bypass_reg <= 1'b0;
      end else if (state == SHIFT_DR) begin
        bypass_reg <= tdi_s;
      end
    end
  end

  // Identity register: reloads its fixed value at capture, shifts toward bit 0.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idcode_shift <= IDCODE_VALUE;
    end else if (tck_rise && dr_sel == SEL_IDCODE) begin
      if (state == CAPTURE_DR) begin
        idcode_shift <= IDCODE_VALUE;
      end else if (state == SHIFT_DR) begin
        idcode_shift <= {tdi_s, idcode_shift[IDCODE_WIDTH-1:1]};
      end
    end
  end

  // Debug control shift register: captures the current word for read-back.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      debug_shift <= DEBUG_CTRL_RESET;
    end else if (tck_rise && dr_sel == SEL_DEBUG_CTRL) begin
      if (state == CAPTURE_DR) begin
        debug_shift <= test_debug_control_reg;
      end else if (state == SHIFT_DR) begin
        debug_shift <= {tdi_s, debug_shift[DEBUG_CTRL_W-1:1]};
      end
    end
  end

  // Boundary stage: forwards the chain input, captured and shifted alike.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boundary_bit <= 1'b0;
    end else if (tck_rise && dr_sel == SEL_BOUNDARY) begin
      if (state == CAPTURE_DR || state == SHIFT_DR) begin
        boundary_bit <= chain_s;
      end
    end
  end

  // Parallel debug control word, changed only by update-data.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      test_debug_control_reg <= DEBUG_CTRL_RESET;
    end else if (!trst_n_s) begin
      test_debug_control_reg <= DEBUG_CTRL_RESET;
    end else if (tck_fall && state == UPDATE_DR && dr_sel == SEL_DEBUG_CTRL && private_code) begin
      test_debug_control_reg <= debug_shift;
    end
  end

  // The program bit pin follows its register bit one clock later.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      debug_program_bit_out <= DEBUG_CTRL_RESET[PROGRAM_BIT_POS];
    end else if (!trst_n_s) begin
      debug_program_bit_out <= DEBUG_CTRL_RESET[PROGRAM_BIT_POS];
    end else begin
      debug_program_bit_out <= test_debug_control_reg[PROGRAM_BIT_POS];
    end
  end

  // Serial output source for the current shift state.
  always_comb begin
    next_tdo = 1'b0;
    case (state)
      SHIFT_IR: next_tdo = ir_shift[0];
      SHIFT_DR: begin
        case (dr_sel)
          SEL_BYPASS:     next_tdo = bypass_reg;
          SEL_IDCODE:     next_tdo = idcode_shift[0];
          SEL_DEBUG_CTRL: next_tdo = debug_shift[0];
          SEL_BOUNDARY:   next_tdo = boundary_bit;
          default:        next_tdo = bypass_reg;
        endcase
      end
      default: next_tdo = 1'b0;
    endcase
  end

  // Serial data out moves only on the falling edge of the test clock.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      test_data_out <= 1'b0;
    end else if (tck_fall) begin
      test_data_out <= next_tdo;
    end
  end

  // The enable drops at once on test reset and otherwise follows shifting.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      test_data_out_enable <= 1'b0;
    end else if (!trst_n_s) begin
      test_data_out_enable <= 1'b0;
    end else if (tck_fall) begin
      test_data_out_enable <= (state == SHIFT_IR) || (state == SHIFT_DR);
    end
  end

  // External test flag follows the decoded current instruction.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      external_test_selected <= 1'b0;
    end else begin
      external_test_selected <= trst_n_s && (instr == INSTR_EXTEST);
    end
  end

endmodule

// ==== include/jtag_tap_pkg.sv ====
// Constants, instruction codes and state types of the test-access-port logic.
// Assumes one core clock domain that oversamples the test clock pin.
package jtag_tap_pkg;

  // Controller states.
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR_SCAN,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR_SCAN,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_e;

  // Data register chosen by the decoded instruction.
  typedef enum logic [1:0] {
    SEL_BYPASS,
    SEL_IDCODE,
    SEL_BOUNDARY,
    SEL_DEBUG_CTRL
  } dr_select_e;

  localparam int IR_WIDTH        = 4;
  localparam int LOW_IR_WIDTH    = 3;
  localparam int INSTR_WIDTH     = 7;
  localparam int IDCODE_WIDTH    = 32;
  localparam int DEBUG_CTRL_W    = 8;
  localparam int PROGRAM_BIT_POS = 0;
  localparam int SYNC_WIDTH      = 8;

  // Combined instruction codes: upper nibble local, low three bits chained.
  localparam logic [6:0] INSTR_EXTEST     = 7'h78;
  localparam logic [6:0] INSTR_RESERVED   = 7'h79;
  localparam logic [6:0] INSTR_SAMPLE     = 7'h7A;
  localparam logic [6:0] INSTR_IDCODE     = 7'h7B;
  localparam logic [6:0] INSTR_HIGHZ      = 7'h7D;
  localparam logic [6:0] INSTR_CLAMP      = 7'h7E;
  localparam logic [6:0] INSTR_BYPASS     = 7'h7F;
  localparam logic [6:0] INSTR_DEBUG_CTRL = 7'h2C;
  localparam logic [2:0] PRIVATE_LOW      = 3'h4;

  // Upper nibbles of the private debug codes.
  localparam logic [31:0] PRIVATE_NIBBLES = 32'h579ABCDE;

  localparam logic [3:0] IR_RESET         = 4'hF;
  localparam logic [3:0] IR_CAPTURE       = 4'h1;
  localparam logic [7:0] DEBUG_CTRL_RESET = 8'h00;
  // Identification value is arbitrary; bit 0 must be one.
  localparam logic [31:0] IDCODE_DEFAULT  = 32'h00000001;

  // Synchroniser vector: tck, tms, tdi, trst_n, chain, low[2:0].
  // Reset values are the idle pin levels, so no false test-clock edge follows reset.
  localparam logic [7:0] SYNC_RESET       = 8'hE0;
  localparam int SYNC_TCK    = 7;
  localparam int SYNC_TMS    = 6;
  localparam int SYNC_TDI    = 5;
  localparam int SYNC_TRST_N = 4;
  localparam int SYNC_CHAIN  = 3;

  // Bench test clock period and core clock period in ns.
  localparam int TCK_PERIOD_NS = 160;
  localparam int CLK_PERIOD_NS = 10;

endpackage

// ==== testbench/jtag_tap_controller_properties.sv ====
// Checker of the test-access-port controller, watching only its ports.
// Assumes ref_clk oversamples the test clock pin ten to nineteen times.
`timescale 1ns/1ps
module jtag_tap_checker
  import jtag_tap_pkg::*;
(
  // Core clock and reset.
  input wire logic                    ref_clk,
  input wire logic                    rst,
  // Test port pins.
  input wire logic                    test_clock_in,
  input wire logic                    test_mode_select_in,
  input wire logic                    test_data_in,
  input wire logic                    test_reset_n_in,
  input wire logic                    chain_scan_in,
  input wire logic [LOW_IR_WIDTH-1:0] chained_ir_low_in,
  // Controller outputs.
  input wire logic                    test_data_out,
  input wire logic                    test_data_out_enable,
  input wire logic                    external_test_selected,
  input wire logic                    capture_data_state,
  input wire logic                    shift_data_state,
  input wire logic                    update_data_state,
  input wire logic                    debug_program_bit_out
);
  logic       tck_d;
  logic [4:0] since_rise;
  logic [4:0] since_fall;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || !test_reset_n_in);

  // Cycles since the test clock pin last rose or fell, saturating.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tck_d      <= 1'b0;
      since_rise <= 5'h1F;
      since_fall <= 5'h1F;
    end else begin
      tck_d      <= test_clock_in;
      since_rise <= (test_clock_in && !tck_d) ? 5'h00 : since_rise + 5'(since_rise != 5'h1F);
      since_fall <= (!test_clock_in && tck_d) ? 5'h00 : since_fall + 5'(since_fall != 5'h1F);
    end
  end

  AST_TDO_ON_FALL: assert property ($changed(test_data_out) |-> since_fall <= 5'h06)
    else $error("serial output changed away from a test clock fall");
  AST_ENABLE_ON_FALL: assert property ($changed(test_data_out_enable)
    |-> since_fall <= 5'h06)
    else $error("output enable changed away from a test clock fall");
  AST_FLAGS_ON_RISE: assert property (
    $changed({capture_data_state, shift_data_state, update_data_state}) |-> since_rise <= 5'h06)
    else $error("state flags changed away from a test clock rise");
  AST_ONE_FLAG: assert property (
    $onehot0({capture_data_state, shift_data_state, update_data_state}))
    else $error("more than one state flag high");
  AST_UPDATE_FROM_EXIT: assert property ($rose(update_data_state)
    |-> $past(!capture_data_state && !shift_data_state))
    else $error("update entered straight from capture or shift");
  AST_CAPTURE_ONE_TCK: assert property ($rose(capture_data_state)
    |-> capture_data_state[*8] ##[4:12] !capture_data_state)
    else $error("capture state did not last one test clock");
  AST_SHIFT_ENABLE: assert property ($rose(shift_data_state)
    |-> !test_data_out_enable ##[5:12] test_data_out_enable)
    else $error("output enable did not follow entry to shift");
  AST_IDLE_RELEASE: assert property ((capture_data_state || update_data_state)
    |-> !test_data_out_enable)
    else $error("output enabled outside shifting");
  AST_PROGRAM_BIT_HELD: assert property ($changed(debug_program_bit_out)
    |-> update_data_state)
    else $error("program bit changed outside update");

  COV_UPDATE: cover property ($rose(update_data_state));
  COV_ENABLE: cover property ($rose(test_data_out_enable));
  COV_PROGRAM: cover property ($changed(debug_program_bit_out));
endmodule

bind jtag_tap_controller jtag_tap_checker chk (
  .ref_clk, .rst, .test_clock_in, .test_mode_select_in, .test_data_in, .test_reset_n_in,
  .chain_scan_in, .chained_ir_low_in, .test_data_out, .test_data_out_enable,
  .external_test_selected, .capture_data_state, .shift_data_state, .update_data_state,
  .debug_program_bit_out
);

// ==== testbench/jtag_tester_model.sv ====
// Behavioural tester driving the test port pins of the controller.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module jtag_tester_model
  import jtag_tap_pkg::*;
(
  // Test port pins toward the device.
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n
);
  // Clock stands high between frames; mode and data idle high like a pull-up.
  initial begin
    tck    = 1'b1;
    tms    = 1'b1;
    tdi    = 1'b1;
    trst_n = 1'b0;
    #(20*CLK_PERIOD_NS);
    trst_n = 1'b1;
  end

  // New mode and data go out on the fall and hold through the rise.
  task automatic fall(input bit m, input bit d);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #(TCK_PERIOD_NS/2);
  endtask

  task automatic rise();
    tck = 1'b1;
    #(TCK_PERIOD_NS/2);
  endtask

  task automatic pulse_reset();
    trst_n = 1'b0;
    #(8*CLK_PERIOD_NS);
    trst_n = 1'b1;
    #(4*CLK_PERIOD_NS);
  endtask
endmodule

// ==== testbench/jtag_tap_controller_bench.sv ====
// Self-checking bench of the test-access-port controller with a reference model.
// Assumes the tester model drives the test pins and this module the core side.
`timescale 1ns/1ps
module jtag_tap_controller_bench
  import jtag_tap_pkg::*;
;
  // Arbitrary identity value with bit 0 set.
  localparam logic [31:0] ID = 32'h6B2D4C37;
  logic                    ref_clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    chain_scan_in = 1'b0;
  logic [LOW_IR_WIDTH-1:0] chained_ir_low_in = 3'h3;
  logic test_clock_in, test_mode_select_in, test_data_in, test_reset_n_in;
  logic test_data_out, test_data_out_enable, external_test_selected;
  logic capture_data_state, shift_data_state, update_data_state, debug_program_bit_out;
  int          n_fail = 0;
  int          checked = 0;
  int          seed = 66;
  int          st = 0;
  int          len = 1;
  bit          chk = 1'b0;
  bit          bnd = 1'b0;
  logic [3:0]  ir = IR_RESET;
  logic [7:0]  dbg = DEBUG_CTRL_RESET;
  logic [31:0] sr = 32'h0;
  logic [6:0]  pick;
  int          n0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
  int          n1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
  logic [6:0]  std_code[7] = '{INSTR_EXTEST, INSTR_RESERVED, INSTR_SAMPLE, INSTR_IDCODE,
                               INSTR_HIGHZ, INSTR_CLAMP, INSTR_BYPASS};

  always #(CLK_PERIOD_NS/2) ref_clk = ~ref_clk;

  jtag_tap_controller #(.IDCODE_VALUE(ID)) dut (
    .ref_clk, .rst, .test_clock_in, .test_mode_select_in, .test_data_in, .test_reset_n_in,
    .chain_scan_in, .chained_ir_low_in, .test_data_out, .test_data_out_enable,
    .external_test_selected, .capture_data_state, .shift_data_state, .update_data_state,
    .debug_program_bit_out);
  jtag_tester_model tester (.tck(test_clock_in), .tms(test_mode_select_in),
    .tdi(test_data_in), .trst_n(test_reset_n_in));

  task automatic cmp(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One test clock period; outputs are compared with the model between fall and rise.
  task automatic tick(input bit m, input bit d);
    logic [6:0] code;
    bit         sh;
    if (st == 0) ir = IR_RESET;
    if (st == 15) ir = sr[3:0];
    if (st == 8 && {ir, chained_ir_low_in} == INSTR_DEBUG_CTRL) dbg = sr[7:0];
    tester.fall(m, d);
    code = {ir, chained_ir_low_in};
    sh = (st == 4 || st == 11);
    cmp(test_data_out_enable, sh);
    if (sh && chk) cmp(test_data_out, bnd ? chain_scan_in : sr[0]);
    cmp(capture_data_state, st == 3);
    cmp(shift_data_state, st == 4);
    cmp(update_data_state, st == 8);
    cmp(external_test_selected, code == INSTR_EXTEST);
    cmp(debug_program_bit_out, dbg[PROGRAM_BIT_POS]);
    if (st == 10) begin
      sr = 32'(IR_CAPTURE);
      len = IR_WIDTH;
      chk = 1'b1;
      bnd = 1'b0;
    end
    if (st == 3) begin
      len = (code == INSTR_IDCODE) ? IDCODE_WIDTH : (code == INSTR_DEBUG_CTRL) ? DEBUG_CTRL_W : 1;
      sr = (code == INSTR_IDCODE) ? ID : (code == INSTR_DEBUG_CTRL) ? 32'(dbg) : 32'h0;
      bnd = code inside {INSTR_EXTEST, INSTR_SAMPLE};
      chk = 1'b1;
    end
    if (sh) begin
      sr = sr >> 1;
      sr[len-1] = d;
    end
    st = m ? n1[st] : n0[st];
    tester.rise();
  endtask

  task automatic ir_scan(input logic [3:0] nib);
    tick(1, 0);
    tick(1, 0);
    tick(0, 0);
    tick(0, 0);
    for (int j = 0; j < IR_WIDTH; j++) tick(j == IR_WIDTH - 1, nib[j]);
    tick(0, 0);
    tick(1, 0);
    tick(1, 0);
    tick(0, 0);
  endtask

  // Data scan with a pause halfway, returning to idle.
  task automatic dr_scan(input int n);
    chain_scan_in = 1'($random(seed));
    tick(1, 0);
    tick(0, 0);
    tick(0, 0);
    for (int j = 0; j < n; j++) begin
      tick(j == n - 1 || j == n / 2, 1'($random(seed)));
      if (j == n / 2 && j != n - 1) begin
        tick(0, 0);
        tick(1, 0);
        tick(0, 0);
      end
    end
    tick(1, 0);
    tick(0, 0);
  endtask

  initial begin
    #(50000*CLK_PERIOD_NS);
    n_fail++;
    results();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    #3;
    rst = 1'b0;
    repeat (30) @(posedge ref_clk);
    #3;
    for (int i = 0; i < 5; i++) tick(1, 1'($random(seed)));
    tick(0, 0);
    dr_scan(IDCODE_WIDTH);
    for (int i = 0; i < 15; i++) begin
      pick = (i < 7) ? std_code[i] : {PRIVATE_NIBBLES[31-4*(i-7) -: 4], PRIVATE_LOW};
      chained_ir_low_in = pick[2:0];
      ir_scan(pick[6:3]);
      dr_scan((pick == INSTR_DEBUG_CTRL) ? DEBUG_CTRL_W : 20);
      if (pick == INSTR_DEBUG_CTRL) dr_scan(DEBUG_CTRL_W);
    end
    tick(1, 0);
    tick(0, 0);
    tick(0, 0);
    tick(0, 1);
    tester.pulse_reset();
    st = 0;
    ir = IR_RESET;
    dbg = DEBUG_CTRL_RESET;
    tick(0, 0);
    chained_ir_low_in = INSTR_IDCODE[2:0];
    dr_scan(IDCODE_WIDTH);
    results();
  end
endmodule
